// ### include/ivgc_pkg.sv
// Constants for the interrupt vector and global control register bank
package ivgc_pkg;

    // ------------------------------------------------------------
    // Register addresses on the core data bus
    // ------------------------------------------------------------
    localparam logic [15:0] IVGC_GLOBAL_CONTROL_ADDR = 16'hFFB1;
    localparam logic [15:0] IVGC_SOURCE_VECTOR_ADDR = 16'hFFB2;

    // ------------------------------------------------------------
    // Global control field positions and reset value
    // ------------------------------------------------------------
    localparam int IVGC_GC_CLK_BIT = 7;
    localparam int IVGC_GC_EXT_BIT = 6;
    localparam int IVGC_GC_P1PU_BIT = 5;
    localparam int IVGC_GC_GPA_BIT = 4;
    localparam int IVGC_GC_GPB_BIT = 3;
    localparam int IVGC_GC_USB_BIT = 2;
    localparam int IVGC_GC_P3PU_BIT = 1;
    localparam int IVGC_GC_CODEC_BIT = 0;
    localparam logic [7:0] IVGC_GC_RESET = 8'h00;

    // ------------------------------------------------------------
    // Vector codes and pending-source layout
    // ------------------------------------------------------------
    localparam int IVGC_NSRC = 34;
    localparam logic [5:0] IVGC_VEC_OUT_EP0 = 6'h00;
    localparam logic [5:0] IVGC_VEC_IN_EP0 = 6'h08;
    localparam logic [5:0] IVGC_VEC_OVERWRITE = 6'h10;
    localparam logic [5:0] IVGC_VEC_SETUP = 6'h12;
    localparam logic [5:0] IVGC_VEC_CODEC_RX = 6'h18;
    localparam logic [5:0] IVGC_VEC_CODEC_TX = 6'h19;
    localparam logic [5:0] IVGC_VEC_DMA0 = 6'h20;
    localparam logic [5:0] IVGC_VEC_DMA1 = 6'h21;
    localparam logic [5:0] IVGC_VEC_NONE = 6'h24;
    localparam logic [7:0] IVGC_RDATA_RESET = 8'h00;
    // Codes that belong to powered-down USB blocks: 00h to 17h
    localparam logic [33:0] IVGC_USB_MASK = 34'h000FFFFFF;
    localparam logic [33:0] IVGC_CODEC_MASK = 34'h003000000;
    // Codes that may legally be pending (reserved 11h, 1Ah, 1Bh excluded)
    localparam logic [33:0] IVGC_LEGAL_MASK = 34'h3F3FDFFFF;

endpackage

// ### design/ivgc_bank.sv
// Interrupt source vector and global control register bank
`timescale 1ns/1ps

// Summary of operation
// - Vector register bits 7:6 read zero; code sits in bits 5:0.
// - DMA channel 0 reports 20h, channel 1 reports 21h.
// - No pending interrupt reports 24h; reserved codes never appear.
// - USB events encode 12h setup through 17h bus reset.
// - Codec receive full is 18h, transmit empty 19h; 1Ah, 1Bh unused.
// - Core runs 12 MHz while clock select is 0, 24 MHz at 1.
// - Clock select, once set, ignores writes of 0 until reset.
// - External interrupt reaches the request line only when enabled.
// - Control bit 5 set disables port 1 pull-ups.
// - Control bit 1 set disables port 3 pull-ups.
// - Low power bit at 0 powers down all USB blocks.
// - Codec port operates only while control bit 0 is 1.
// - All sources OR into one active-low request line to the core.
// - Any write to the vector clears that source unless it fires again in that cycle, shows next.
// - Priority by code, 21h highest, control endpoint zero on top.
module ivgc_bank
    import ivgc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] out_ep_event,
    input wire logic [7:0] in_ep_event,
    input wire logic setup_overwrite_event,
    input wire logic [5:0] usb_event,
    input wire logic [1:0] codec_event,
    input wire logic [3:0] i2c_event,
    input wire logic [1:0] dma_event,
    input wire logic ext_irq_pin,
    output logic core_irq_line_n,
    output logic core_clock_select,
    output logic ext_irq_enable,
    output logic port_one_pullup_off,
    output logic gp_pin_a,
    output logic gp_pin_b,
    output logic usb_power_on,
    output logic port_three_pullup_off,
    output logic codec_port_enable
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [5:0] ivgc_encode(input logic [IVGC_NSRC-1:0] p);
        logic [5:0] code;
        code = IVGC_VEC_NONE;
        for (int i = 0; i < IVGC_NSRC; i++)
        begin
            if (p[i])
            begin
                code = 6'(i);
            end
        end
        if (p[IVGC_VEC_OUT_EP0])
        begin
            code = IVGC_VEC_OUT_EP0;
        end
        if (p[IVGC_VEC_IN_EP0])
        begin
            code = IVGC_VEC_IN_EP0;
        end
        if (p[IVGC_VEC_SETUP])
        begin
            code = IVGC_VEC_SETUP;
        end
        return code;
    endfunction

    function automatic logic ivgc_legal(input logic [5:0] code);
        return (code == IVGC_VEC_NONE) || ((code < 6'(IVGC_NSRC)) && IVGC_LEGAL_MASK[code]);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] gctl;
    logic [IVGC_NSRC-1:0] pend;
    logic [5:0] vec;
    logic ext_meta;
    logic ext_sync;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic gc_sel = bus_addr == IVGC_GLOBAL_CONTROL_ADDR;
    wire logic vec_sel = bus_addr == IVGC_SOURCE_VECTOR_ADDR;
    wire logic gc_wr = bus_wr && gc_sel;
    wire logic vec_wr = bus_wr && vec_sel;

    // ------------------------------------------------------------
    // Global control next value
    // ------------------------------------------------------------
    // Clock select is sticky: a written 0 cannot slow the core back down
    wire logic [7:0] gc_written = {bus_wdata[IVGC_GC_CLK_BIT] | gctl[IVGC_GC_CLK_BIT],
                                   bus_wdata[IVGC_GC_EXT_BIT:0]};
    wire logic [7:0] next_gctl = gc_wr ? gc_written : gctl;

    // ------------------------------------------------------------
    // Interrupt sources by vector code
    // ------------------------------------------------------------
    wire logic [IVGC_NSRC-1:0] raw_event = {dma_event,
                                            i2c_event,
                                            2'b00,
                                            codec_event,
                                            usb_event,
                                            1'b0,
                                            setup_overwrite_event,
                                            in_ep_event,
                                            out_ep_event};
    // Powered-down USB and idle codec port raise nothing
    wire logic [IVGC_NSRC-1:0] usb_gate = usb_power_on ? '1 : ~IVGC_USB_MASK;
    wire logic [IVGC_NSRC-1:0] codec_gate = codec_port_enable ? '1 : ~IVGC_CODEC_MASK;
    wire logic [IVGC_NSRC-1:0] set_ev = raw_event & usb_gate & codec_gate & IVGC_LEGAL_MASK;
    wire logic [IVGC_NSRC-1:0] clr_ev;
    wire logic [IVGC_NSRC-1:0] next_pend;

    genvar g;
    generate
        for (g = 0; g < IVGC_NSRC; g++)
        begin : g_src
            assign clr_ev[g] = vec_wr && (vec == 6'(g));
            // A new event in the clearing cycle stays pending
            assign next_pend[g] = set_ev[g] | (pend[g] & ~clr_ev[g]);
        end
    endgenerate

    wire logic [5:0] next_vec = ivgc_encode(next_pend);
    wire logic ext_active = ext_sync && gctl[IVGC_GC_EXT_BIT];
    wire logic next_irq_n = !((|next_pend) || ext_active);
    wire logic [7:0] next_rdata = (bus_rd && vec_sel) ? {2'b00, vec} :
                                  (bus_rd && gc_sel) ? gctl : IVGC_RDATA_RESET;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            gctl <= IVGC_GC_RESET;
            pend <= '0;
            vec <= IVGC_VEC_NONE;
            core_irq_line_n <= 1'b1;
            bus_rdata <= IVGC_RDATA_RESET;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end
        else if (ce)
        begin
            gctl <= next_gctl;
            pend <= next_pend;
            vec <= next_vec;
            core_irq_line_n <= next_irq_n;
            bus_rdata <= next_rdata;
            ext_meta <= ext_irq_pin;
            ext_sync <= ext_meta;
        end
    end

    // ------------------------------------------------------------
    // Control outputs straight from the register
    // ------------------------------------------------------------
    assign core_clock_select = gctl[IVGC_GC_CLK_BIT];
    assign ext_irq_enable = gctl[IVGC_GC_EXT_BIT];
    assign port_one_pullup_off = gctl[IVGC_GC_P1PU_BIT];
    assign gp_pin_a = gctl[IVGC_GC_GPA_BIT];
    assign gp_pin_b = gctl[IVGC_GC_GPB_BIT];
    assign usb_power_on = gctl[IVGC_GC_USB_BIT];
    assign port_three_pullup_off = gctl[IVGC_GC_P3PU_BIT];
    assign codec_port_enable = gctl[IVGC_GC_CODEC_BIT];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    wire logic ep0_pend = pend[IVGC_VEC_SETUP] | pend[IVGC_VEC_IN_EP0] | pend[IVGC_VEC_OUT_EP0];

    vec_reserved_zero_a: assert property (
        ce && bus_rd && vec_sel |=> bus_rdata[7:6] == 2'b00 && bus_rdata[5:0] == $past(vec))
        else $error("vector read shows nonzero reserved bits");

    dma_code_a: assert property (
        ce && !bus_wr && pend == '0 && set_ev == ({{(IVGC_NSRC-1){1'b0}}, 1'b1} << IVGC_VEC_DMA0)
        |=> vec == IVGC_VEC_DMA0)
        else $error("dma channel 0 not reported as 20h");

    idle_code_a: assert property (
        ce && next_pend == '0 |=> vec == IVGC_VEC_NONE)
        else $error("idle vector is not 24h");

    legal_code_a: assert property (
        ivgc_legal(vec))
        else $error("vector shows a reserved code");

    clock_sticky_a: assert property (
        core_clock_select |=> core_clock_select)
        else $error("clock select cleared without reset");

    ext_gate_a: assert property (
        ce && !gctl[IVGC_GC_EXT_BIT] && next_pend == '0 |=> core_irq_line_n)
        else $error("disabled external interrupt reached the core");

    pullup_write_a: assert property (
        ce && gc_wr |=> port_one_pullup_off == $past(bus_wdata[IVGC_GC_P1PU_BIT])
        && port_three_pullup_off == $past(bus_wdata[IVGC_GC_P3PU_BIT]))
        else $error("pull-up disable bits did not follow the write");

    vec_clear_a: assert property (
        ce && vec_wr && vec != IVGC_VEC_NONE && !set_ev[vec] |=> !pend[$past(vec)])
        else $error("vector write did not clear its source");

    ep0_top_a: assert property (
        ce && next_pend[IVGC_VEC_SETUP] |=> vec == IVGC_VEC_SETUP)
        else $error("control endpoint zero setup not on top");

    usb_off_a: assert property (
        ce && !usb_power_on |=> (pend & IVGC_USB_MASK) == ($past(pend) & IVGC_USB_MASK
        & ~$past(clr_ev)))
        else $error("powered-down usb raised an interrupt");

    irq_any_a: assert property (
        ce && next_pend != '0 |=> !core_irq_line_n)
        else $error("pending source did not assert the request line");

    irq_idle_a: assert property (
        ce && next_pend == '0 && !ext_active |=> core_irq_line_n)
        else $error("request line low with nothing pending");

    ext_line_a: assert property (
        ce && ext_active |=> !core_irq_line_n)
        else $error("enabled external interrupt did not reach the core");

    // ------------------------------------------------------------
    // Checks on source mapping, clock enable and reset
    // ------------------------------------------------------------
    // Freeze must cover every flop, or a stalled core loses an event
    ce_freeze_a: assert property (
        !ce |=> $stable(gctl) && $stable(pend) && $stable(vec) && $stable(bus_rdata))
        else $error("state changed while clock enable was low");

    usb_event_code_a: assert property (
        ce && usb_power_on
        |=> (pend[IVGC_VEC_SETUP +: 6] & $past(usb_event)) == $past(usb_event))
        else $error("usb event did not reach codes 12h to 17h");

    codec_event_code_a: assert property (
        ce && codec_port_enable
        |=> (pend[IVGC_VEC_CODEC_RX +: 2] & $past(codec_event)) == $past(codec_event))
        else $error("codec event did not reach codes 18h and 19h");

    ep_event_code_a: assert property (
        ce && usb_power_on
        |=> (pend[IVGC_VEC_OUT_EP0 +: 8] & $past(out_ep_event)) == $past(out_ep_event)
        && (pend[IVGC_VEC_IN_EP0 +: 8] & $past(in_ep_event)) == $past(in_ep_event))
        else $error("endpoint completion did not reach its own code");

    // Reserved codes have no source, so they can never be served
    legal_pend_a: assert property (
        (pend & ~IVGC_LEGAL_MASK) == '0)
        else $error("reserved code pending");

    codec_gate_a: assert property (
        ce && !codec_port_enable |=> (pend & IVGC_CODEC_MASK)
        == ($past(pend) & IVGC_CODEC_MASK & ~$past(clr_ev)))
        else $error("disabled codec port raised an interrupt");

    gp_pin_write_a: assert property (
        ce && gc_wr |=> gp_pin_a == $past(bus_wdata[IVGC_GC_GPA_BIT])
        && gp_pin_b == $past(bus_wdata[IVGC_GC_GPB_BIT]))
        else $error("general purpose pins did not follow the write");

    clock_set_a: assert property (
        ce && gc_wr && bus_wdata[IVGC_GC_CLK_BIT] |=> core_clock_select)
        else $error("clock select did not set on write of 1");

    // Stale read data would look like a real vector to the core
    rdata_idle_a: assert property (
        ce && !bus_rd |=> bus_rdata == IVGC_RDATA_RESET)
        else $error("read data not cleared after its cycle");

    // Reset acts whatever clock enable does, so the default disable is set aside
    ctrl_reset_a: assert property (@(posedge clk) disable iff (1'b0)
        !resetn |=> gctl == IVGC_GC_RESET && pend == '0 && vec == IVGC_VEC_NONE
        && core_irq_line_n && bus_rdata == IVGC_RDATA_RESET)
        else $error("reset did not clear the bank");

    cover_clear_next_c: cover property (ce && vec_wr && ep0_pend ##1 vec != IVGC_VEC_NONE);
    cover_dma_c: cover property (vec == IVGC_VEC_DMA1);
    cover_set_clear_c: cover property (ce && vec_wr && set_ev[vec]);
    cover_fast_clock_c: cover property (ce && gc_wr && !bus_wdata[7] && core_clock_select);
    cover_ext_irq_c: cover property (ce && ext_active && !core_irq_line_n);

endmodule

// ### verification/ivgc_event_model.sv
// Event source model standing in for the blocks that raise interrupts
`timescale 1ns/1ps
module ivgc_event_model (
    input wire logic clk,
    output logic [7:0] out_ep_event,
    output logic [7:0] in_ep_event,
    output logic setup_overwrite_event,
    output logic [5:0] usb_event,
    output logic [1:0] codec_event,
    output logic [3:0] i2c_event,
    output logic [1:0] dma_event,
    output logic ext_irq_pin
);
    // ------------------------------------------------------------
    // Strobes indexed by vector code
    // ------------------------------------------------------------
    logic [33:0] strobe = 34'h000000000;
    assign out_ep_event = strobe[7:0];
    assign in_ep_event = strobe[15:8];
    assign setup_overwrite_event = strobe[16];
    assign usb_event = strobe[23:18];
    assign codec_event = strobe[25:24];
    assign i2c_event = strobe[31:28];
    assign dma_event = strobe[33:32];
    initial ext_irq_pin = 1'b0;
    // Pulses last one cycle; a held level would re-raise a cleared source
    task automatic fire(input logic [33:0] codes);
        @(negedge clk);
        strobe = codes;
        @(negedge clk);
        strobe = 34'h000000000;
    endtask
    // Level input, not tied to the clock on the real pin
    task automatic set_ext(input logic level);
        @(negedge clk);
        ext_irq_pin = level;
    endtask
endmodule

// ### verification/test_ivgc_bank.sv
// Self-checking bench for the vector and global control bank
`timescale 1ns/1ps
module test_ivgc_bank import ivgc_pkg::*; ;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    wire logic [7:0] bus_rdata, out_ep_event, in_ep_event;
    wire logic [5:0] usb_event;
    wire logic [3:0] i2c_event;
    wire logic [1:0] codec_event, dma_event;
    wire logic setup_overwrite_event, ext_irq_pin, core_irq_line_n;
    wire logic [7:0] gc_pins;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rd_val;
    logic [33:0] mask;
    logic [5:0] prio_seq [8] = '{6'h12, 6'h08, 6'h00, 6'h21, 6'h20, 6'h1F, 6'h18, 6'h05};

    ivgc_event_model ivgc_event_model_inst (.clk(clk), .out_ep_event(out_ep_event),
        .in_ep_event(in_ep_event), .setup_overwrite_event(setup_overwrite_event),
        .usb_event(usb_event), .codec_event(codec_event), .i2c_event(i2c_event),
        .dma_event(dma_event), .ext_irq_pin(ext_irq_pin));
    ivgc_bank ivgc_bank_inst (.clk(clk), .resetn(resetn), .ce(ce), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .out_ep_event(out_ep_event), .in_ep_event(in_ep_event),
        .setup_overwrite_event(setup_overwrite_event), .usb_event(usb_event),
        .codec_event(codec_event), .i2c_event(i2c_event), .dma_event(dma_event),
        .ext_irq_pin(ext_irq_pin), .core_irq_line_n(core_irq_line_n),
        .core_clock_select(gc_pins[7]), .ext_irq_enable(gc_pins[6]),
        .port_one_pullup_off(gc_pins[5]), .gp_pin_a(gc_pins[4]), .gp_pin_b(gc_pins[3]),
        .usb_power_on(gc_pins[2]), .port_three_pullup_off(gc_pins[1]),
        .codec_port_enable(gc_pins[0]));

    // ------------------------------------------------------------
    // Clock, timeout, bus tasks and compares
    // ------------------------------------------------------------
    initial forever #4 clk = ~clk;
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk);
        {bus_wr, bus_addr, bus_wdata} = {1'b1, addr, data};
        @(negedge clk);
        bus_wr = 1'b0;
    endtask
    // Read data is registered, so it is taken in the cycle after the strobe
    task automatic rd(input logic [15:0] addr, output logic [7:0] data);
        @(negedge clk);
        {bus_rd, bus_addr} = {1'b1, addr};
        @(negedge clk);
        bus_rd = 1'b0;
        data = bus_rdata;
    endtask
    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_byte(name, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic stop_test();
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        chk_bit("irq line", 1'b1, core_irq_line_n);
        chk_byte("control pins", IVGC_GC_RESET, gc_pins);
        rd(IVGC_GLOBAL_CONTROL_ADDR, rd_val);
        chk_byte("control", IVGC_GC_RESET, rd_val);
        rd(16'hFFB3, rd_val);
        chk_byte("unmapped", 8'h00, rd_val);
        // Blocks powered down and codec port off: events are dropped
        ivgc_event_model_inst.fire(34'h001040000);
        rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
        chk_byte("vector", 8'h24, rd_val);
        for (int i = 0; i < 7; i++)
        begin
            wr(IVGC_GLOBAL_CONTROL_ADDR, 8'h01 << i);
            chk_byte("control pins", 8'h01 << i, gc_pins);
        end
        wr(IVGC_GLOBAL_CONTROL_ADDR, 8'h80);
        chk_byte("control pins", 8'h80, gc_pins);
        wr(IVGC_GLOBAL_CONTROL_ADDR, 8'h00);
        rd(IVGC_GLOBAL_CONTROL_ADDR, rd_val);
        chk_byte("control", 8'h80, rd_val);
        wr(IVGC_GLOBAL_CONTROL_ADDR, 8'h85);
        for (logic [5:0] c = 6'h12; c <= 6'h19; c++)
        begin
            mask = 34'h000000000;
            mask[c] = 1'b1;
            ivgc_event_model_inst.fire(mask);
            rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
            chk_byte("vector", {2'b00, c}, rd_val);
            chk_bit("irq line", 1'b0, core_irq_line_n);
            wr(IVGC_SOURCE_VECTOR_ADDR, 8'hFF);
        end
        mask = 34'h000000000;
        for (int i = 0; i < 8; i++)
            mask[prio_seq[i]] = 1'b1;
        ivgc_event_model_inst.fire(mask);
        for (int i = 0; i < 8; i++)
        begin
            rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
            chk_byte("vector", {2'b00, prio_seq[i]}, rd_val);
            chk_bit("irq line", 1'b0, core_irq_line_n);
            wr(IVGC_SOURCE_VECTOR_ADDR, 8'h3C);
        end
        rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
        chk_byte("vector", 8'h24, rd_val);
        chk_bit("irq line", 1'b1, core_irq_line_n);
        ivgc_event_model_inst.set_ext(1'b1);
        repeat (5) @(negedge clk);
        chk_bit("irq line", 1'b1, core_irq_line_n);
        wr(IVGC_GLOBAL_CONTROL_ADDR, 8'hC5);
        repeat (4) @(negedge clk);
        chk_bit("irq line", 1'b0, core_irq_line_n);
        rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
        chk_byte("vector", 8'h24, rd_val);
        ivgc_event_model_inst.set_ext(1'b0);
        repeat (5) @(negedge clk);
        chk_bit("irq line", 1'b1, core_irq_line_n);
        // Clock enable low: writes and events are both lost
        ce = 1'b0;
        wr(IVGC_GLOBAL_CONTROL_ADDR, 8'h00);
        ivgc_event_model_inst.fire(34'h200000000);
        chk_byte("control pins", 8'hC5, gc_pins);
        chk_bit("irq line", 1'b1, core_irq_line_n);
        ce = 1'b1;
        ivgc_event_model_inst.fire(34'h100000000);
        rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
        chk_byte("vector", {2'b00, IVGC_VEC_DMA0}, rd_val);
        // New event in the clearing cycle keeps the source pending
        fork
            wr(IVGC_SOURCE_VECTOR_ADDR, 8'h00);
            ivgc_event_model_inst.fire(34'h100000000);
        join
        rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
        chk_byte("vector", {2'b00, IVGC_VEC_DMA0}, rd_val);
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        chk_byte("control pins", IVGC_GC_RESET, gc_pins);
        chk_bit("irq line", 1'b1, core_irq_line_n);
        rd(IVGC_SOURCE_VECTOR_ADDR, rd_val);
        chk_byte("vector", 8'h24, rd_val);
        stop_test();
    end
endmodule
